// ===== hw/roc_defs.svh
`ifndef ROC_DEFS_SVH
`define ROC_DEFS_SVH

// register byte offsets
`define ROC_OFF_SWITCHES   8'h00
`define ROC_OFF_CHECKSUM   8'h04
`define ROC_OFF_BF_DELAY   8'h08
`define ROC_OFF_STATUS     8'h0C
`define ROC_OFF_IRQ_STAT   8'h10
`define ROC_OFF_IRQ_CLR    8'h14
`define ROC_OFF_IRQ_EN     8'h18
`define ROC_OFF_CONTROL    8'h1C

// output function switch positions (switch n sits at bit n-1)
`define ROC_SW_LATCH_PO1   0
`define ROC_SW_LATCH_PO2   1
`define ROC_SW_LATCH_PO3   2
`define ROC_SW_SIG_PULSE   3
`define ROC_SW_POW_PULSE   4
`define ROC_SW_BF_ENABLE   5
`define ROC_SW_LOCKOUT     6
`define ROC_SW_EXT_WARN    7

// reset values
`define ROC_RST_SWITCHES   8'h00
`define ROC_RST_CHECKSUM   8'h00
`define ROC_RST_IRQ_EN     3'h0

// interrupt status bits
`define ROC_IRQ_CFG_ERR    0
`define ROC_IRQ_BF_FIRED   1
`define ROC_IRQ_PO_RISE    2

// timing
`define ROC_CLK_HZ         100000000
`define ROC_MS_PER_S       1000
`define ROC_PULSE_LONG_MS  80
`define ROC_PULSE_SHORT_MS 40
`define ROC_BF_STEP_MS     10
`define ROC_BF_DEFAULT_MS  100
`define ROC_BF_MIN_MS      100
`define ROC_BF_MAX_MS      60000

`endif

// ===== hw/roc_pkg.sv
package roc_pkg;
    typedef enum logic [2:0] {
        BF_IDLE   = 3'b001,
        BF_TIMING = 3'b010,
        BF_FIRED  = 3'b100
    } roc_bf_state_t;
    typedef logic [7:0] roc_switches_t;
endpackage

// ===== hw/roc_sync2.sv
`timescale 1ns/1ps
module roc_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    // data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else if (ce) begin
            meta_reg <= din;
            sync_reg <= meta_reg;
        end
    end

    assign dout = sync_reg;
endmodule

// ===== hw/roc_out_stretch.sv
`timescale 1ns/1ps
module roc_out_stretch (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic msTick,
    // control
    input wire logic req,
    input wire logic latchEn,
    input wire logic unlatch,
    input wire logic [6:0] lenMs,
    // contact drive
    output logic out
);
    logic reqPrev_reg;
    logic latched_reg;
    logic latched_next;
    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;

    // set wins over unlatch while the cause persists
    always_comb begin
        latched_next = latchEn && (req || (latched_reg && !unlatch));
        cnt_next = cnt_reg;
        if (req && !reqPrev_reg) begin
            // one extra ms covers the phase of the first tick
            cnt_next = 7'(lenMs + 7'h01);
        end else if (msTick && cnt_reg != 7'h00) begin
            cnt_next = 7'(cnt_reg - 7'h01);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            reqPrev_reg <= 1'b0;
            latched_reg <= 1'b0;
            cnt_reg <= 7'h00;
            out <= 1'b0;
        end else if (ce) begin
            reqPrev_reg <= req;
            latched_reg <= latched_next;
            cnt_reg <= cnt_next;
            out <= req || latched_next || cnt_next != 7'h00;
        end
    end

    a_latch_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && latchEn && latched_reg && !unlatch |=> out)
        else $error("latched contact dropped");
    a_plain_release: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && !latchEn && !req && cnt_reg <= 7'h01 && msTick |=> !out)
        else $error("unlatched contact did not release");
    a_unlatch_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && unlatch && !req |=> !latched_reg)
        else $error("unlatch request ignored");
    a_pulse_load: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && req && !reqPrev_reg |=> cnt_reg == $past(lenMs) + 7'h01 && out)
        else $error("minimum pulse not started");
    a_pulse_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && cnt_reg > 7'h01 |=> out)
        else $error("contact dropped before minimum pulse");
endmodule

// ===== hw/roc_relay_top.sv
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "roc_defs.svh"
// Function
// - checksum is sum of 2^(n-1) over switches set to one
// - switches only count as set when computed checksum equals stored one
// - unlatched power output follows its cause; latched one stays on
// - panel, digital input or bus unlatch clears a latched contact
// - signal outputs hold each activation 80 ms, or 40 ms when selected
// - power outputs hold 80 or 40 ms; latching overrides the minimum
// - backup on: lasting trip on output one drives output two after delay
// - lockout switch dedicates third power output to the lockout function
// - warn switch sends supervision or light warning to signal output two
// - backup delay programmable 0.10 to 60.0 s, default 0.10 s
module roc_relay_top
    import roc_pkg::*;
#(
    parameter int TICK_CYCLES = `ROC_CLK_HZ / `ROC_MS_PER_S
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // requests from protection and pins
    input wire logic [2:0] tripIn,
    input wire logic lockoutIn,
    input wire logic [4:0] sigIn,
    input wire logic tcsWarnIn,
    input wire logic lightWarnIn,
    input wire logic unlatchPanelIn,
    input wire logic unlatchDinIn,
    // contacts and flags
    output logic [2:0] powerOut,
    output logic [4:0] signalOut,
    output logic configErr,
    output logic irq
);
    localparam logic [6:0] LEN_LONG = 7'(`ROC_PULSE_LONG_MS);
    localparam logic [6:0] LEN_SHORT = 7'(`ROC_PULSE_SHORT_MS);
    localparam logic [12:0] BF_DEF = 13'(`ROC_BF_DEFAULT_MS / `ROC_BF_STEP_MS);
    localparam logic [12:0] BF_MIN = 13'(`ROC_BF_MIN_MS / `ROC_BF_STEP_MS);
    localparam logic [12:0] BF_MAX = 13'(`ROC_BF_MAX_MS / `ROC_BF_STEP_MS);
    localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

    // synchronised pins
    logic [2:0] tripS;
    logic lockS;
    logic [4:0] sigS;
    logic [3:0] miscS;
    logic tcsS;
    logic lightS;
    logic unlatchPanelS;
    logic unlatchDinS;

    roc_sync2 #(.W(3)) u_sync_trip (
        .sys_clk(sys_clk), .rstn(rstn), .ce(ce),
        .din(tripIn), .dout(tripS)
    );
    roc_sync2 #(.W(5)) u_sync_sig (
        .sys_clk(sys_clk), .rstn(rstn), .ce(ce),
        .din(sigIn), .dout(sigS)
    );
    roc_sync2 #(.W(5)) u_sync_misc (
        .sys_clk(sys_clk), .rstn(rstn), .ce(ce),
        .din({lockoutIn, tcsWarnIn, lightWarnIn, unlatchPanelIn,
              unlatchDinIn}),
        .dout({lockS, miscS})
    );
    assign tcsS = miscS[3];
    assign lightS = miscS[2];
    assign unlatchPanelS = miscS[1];
    assign unlatchDinS = miscS[0];

    // registers
    roc_switches_t switches_reg;
    roc_switches_t checksum_reg;
    roc_switches_t activeCfg_reg;
    logic [12:0] bfDelay_reg;
    logic [2:0] irqStat_reg;
    logic [2:0] irqStat_next;
    logic [2:0] irqEn_reg;
    logic busUnlatch_reg;
    logic [31:0] rdata_next;
    logic addrHit;
    logic wrEn;
    logic rdSetup;
    logic [12:0] wrDelay;

    // checksum of the switch positions
    function automatic logic [7:0] calc_checksum(input roc_switches_t sw);
        logic [7:0] sum;
        sum = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (sw[i]) begin
                sum = 8'(sum + (8'h01 << i));
            end
        end
        return sum;
    endfunction

    logic [7:0] csumCalc;
    logic csumOk;
    assign csumCalc = calc_checksum(switches_reg);
    assign csumOk = csumCalc == checksum_reg;

    // apb decode; zero wait states while enabled
    always_comb begin
        case (paddr)
            `ROC_OFF_SWITCHES, `ROC_OFF_CHECKSUM, `ROC_OFF_BF_DELAY,
            `ROC_OFF_STATUS, `ROC_OFF_IRQ_STAT, `ROC_OFF_IRQ_CLR,
            `ROC_OFF_IRQ_EN, `ROC_OFF_CONTROL: addrHit = 1'b1;
            default: addrHit = 1'b0;
        endcase
    end
    assign pready = ce;
    assign pslverr = psel && penable && !addrHit;
    assign wrEn = psel && penable && ce && pwrite && addrHit;
    assign rdSetup = psel && !penable && !pwrite;

    // out-of-range delays are clamped rather than refused
    always_comb begin
        wrDelay = pwdata[12:0];
        if (pwdata[31:13] != 19'h0 || pwdata[12:0] > BF_MAX) begin
            wrDelay = BF_MAX;
        end else if (pwdata[12:0] < BF_MIN) begin
            wrDelay = BF_MIN;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            switches_reg <= `ROC_RST_SWITCHES;
            checksum_reg <= `ROC_RST_CHECKSUM;
            bfDelay_reg <= BF_DEF;
            irqEn_reg <= `ROC_RST_IRQ_EN;
        end else if (wrEn) begin
            case (paddr)
                `ROC_OFF_SWITCHES: switches_reg <= pwdata[7:0];
                `ROC_OFF_CHECKSUM: checksum_reg <= pwdata[7:0];
                `ROC_OFF_BF_DELAY: bfDelay_reg <= wrDelay;
                `ROC_OFF_IRQ_EN: irqEn_reg <= pwdata[2:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            busUnlatch_reg <= 1'b0;
        end else if (ce) begin
            busUnlatch_reg <= wrEn && paddr == `ROC_OFF_CONTROL && pwdata[0];
        end
    end

    // a half-written configuration keeps the last verified one in force
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            activeCfg_reg <= `ROC_RST_SWITCHES;
            configErr <= 1'b0;
        end else if (ce) begin
            if (csumOk) begin
                activeCfg_reg <= switches_reg;
            end
            configErr <= !csumOk;
        end
    end

    // millisecond tick
    logic [16:0] tickCnt_reg;
    logic msTick;
    assign msTick = tickCnt_reg == TICK_LAST;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            tickCnt_reg <= 17'h00000;
        end else if (ce) begin
            tickCnt_reg <= msTick ? 17'h00000 : 17'(tickCnt_reg + 17'h00001);
        end
    end

    // breaker-failure backup timer
    roc_bf_state_t bfState_reg;
    logic [15:0] bfMs_reg;
    logic [15:0] bfTarget;
    logic bfFire;
    assign bfTarget = 16'({3'h0, bfDelay_reg} * 16'(`ROC_BF_STEP_MS));
    assign bfFire = msTick && 16'(bfMs_reg + 16'h0001) >= bfTarget;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            bfState_reg <= BF_IDLE;
            bfMs_reg <= 16'h0000;
        end else if (ce) begin
            case (bfState_reg)
                BF_IDLE: begin
                    bfMs_reg <= 16'h0000;
                    if (activeCfg_reg[`ROC_SW_BF_ENABLE] && tripS[0]) begin
                        bfState_reg <= BF_TIMING;
                    end
                end
                BF_TIMING: begin
                    if (!activeCfg_reg[`ROC_SW_BF_ENABLE] || !tripS[0]) begin
                        bfState_reg <= BF_IDLE;
                    end else if (bfFire) begin
                        bfState_reg <= BF_FIRED;
                    end else if (msTick) begin
                        bfMs_reg <= 16'(bfMs_reg + 16'h0001);
                    end
                end
                BF_FIRED: begin
                    if (!activeCfg_reg[`ROC_SW_BF_ENABLE] || !tripS[0]) begin
                        bfState_reg <= BF_IDLE;
                    end
                end
                default: bfState_reg <= BF_IDLE;
            endcase
        end
    end

    // output requests
    logic [2:0] powReq;
    logic [4:0] sigReq;
    logic [2:0] powLatch;
    logic unlatchAny;
    logic [6:0] powLen;
    logic [6:0] sigLen;
    logic extWarn;

    assign extWarn = activeCfg_reg[`ROC_SW_EXT_WARN] && (tcsS || lightS);
    assign unlatchAny = unlatchPanelS || unlatchDinS || busUnlatch_reg;
    assign powLatch = activeCfg_reg[`ROC_SW_LATCH_PO3:`ROC_SW_LATCH_PO1];
    assign powLen = activeCfg_reg[`ROC_SW_POW_PULSE] ? LEN_SHORT : LEN_LONG;
    assign sigLen = activeCfg_reg[`ROC_SW_SIG_PULSE] ? LEN_SHORT : LEN_LONG;
    assign powReq[0] = tripS[0];
    assign powReq[1] = tripS[1] || bfState_reg == BF_FIRED;
    // lockout mode gives the third contact to the lockout signal alone
    assign powReq[2] = activeCfg_reg[`ROC_SW_LOCKOUT] ? lockS : tripS[2];
    assign sigReq = {sigS[4:2], sigS[1] || extWarn, sigS[0]};

    for (genvar g = 0; g < 3; g++) begin : g_pow
        roc_out_stretch u_pow (
            .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .msTick(msTick),
            .req(powReq[g]), .latchEn(powLatch[g]), .unlatch(unlatchAny),
            .lenMs(powLen), .out(powerOut[g])
        );
    end
    for (genvar g = 0; g < 5; g++) begin : g_sig
        roc_out_stretch u_sig (
            .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .msTick(msTick),
            .req(sigReq[g]), .latchEn(1'b0), .unlatch(1'b0),
            .lenMs(sigLen), .out(signalOut[g])
        );
    end

    // interrupts; a new event wins over a clear in the same cycle
    logic [2:0] powPrev_reg;
    logic [2:0] irqEvt;
    assign irqEvt[`ROC_IRQ_CFG_ERR] = !csumOk && !configErr;
    assign irqEvt[`ROC_IRQ_BF_FIRED] = bfState_reg == BF_TIMING && bfFire &&
        activeCfg_reg[`ROC_SW_BF_ENABLE] && tripS[0];
    assign irqEvt[`ROC_IRQ_PO_RISE] = |(powerOut & ~powPrev_reg);
    always_comb begin
        irqStat_next = irqStat_reg;
        if (wrEn && paddr == `ROC_OFF_IRQ_CLR) begin
            irqStat_next = irqStat_reg & ~pwdata[2:0];
        end
        irqStat_next = irqStat_next | irqEvt;
    end
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            irqStat_reg <= 3'h0;
            powPrev_reg <= 3'h0;
        end else if (ce) begin
            irqStat_reg <= irqStat_next;
            powPrev_reg <= powerOut;
        end
    end
    assign irq = |(irqStat_reg & irqEn_reg);

    // read data, latched in the setup cycle
    always_comb begin
        case (paddr)
            `ROC_OFF_SWITCHES: rdata_next = {24'h0, switches_reg};
            `ROC_OFF_CHECKSUM: rdata_next = {24'h0, checksum_reg};
            `ROC_OFF_BF_DELAY: rdata_next = {19'h0, bfDelay_reg};
            `ROC_OFF_STATUS: rdata_next = {14'h0, bfState_reg == BF_FIRED,
                signalOut, powerOut, configErr, csumCalc};
            `ROC_OFF_IRQ_STAT: rdata_next = {29'h0, irqStat_reg};
            `ROC_OFF_IRQ_EN: rdata_next = {29'h0, irqEn_reg};
            default: rdata_next = 32'h00000000;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            prdata <= 32'h00000000;
        end else if (ce && rdSetup) begin
            prdata <= rdata_next;
        end
    end

    a_cksum_weight: assert property (@(posedge sys_clk) disable iff (!rstn)
        csumCalc == switches_reg)
        else $error("checksum weighting wrong");
    a_cfg_apply: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && !csumOk |=> activeCfg_reg == $past(activeCfg_reg))
        else $error("unverified switches applied");
    a_cfg_take: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && csumOk ##1 ce |-> activeCfg_reg == $past(switches_reg))
        else $error("verified switches not applied");
    a_cfg_error: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && csumCalc != checksum_reg |=> configErr)
        else $error("configuration error not flagged");
    a_cfg_onset: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(configErr) |-> irqStat_reg[`ROC_IRQ_CFG_ERR])
        else $error("mismatch onset not recorded");
    a_bf_off: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && !activeCfg_reg[`ROC_SW_BF_ENABLE] |=> bfState_reg == BF_IDLE)
        else $error("backup active while disabled");
    a_bf_delay: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(bfState_reg == BF_FIRED) |->
            $past(bfMs_reg) + 16'h0001 >= $past(bfTarget))
        else $error("backup fired early");
    a_lockout_only: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && activeCfg_reg[`ROC_SW_LOCKOUT] && !lockS && !powerOut[2]
            |=> !powerOut[2])
        else $error("trip reached third output in lockout mode");
    a_ext_warn: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && activeCfg_reg[`ROC_SW_EXT_WARN] && (tcsS || lightS)
            |=> signalOut[1])
        else $error("external warning not routed");
endmodule

// ===== testbench/roc_breaker_model.sv
`timescale 1ns/1ps
module roc_breaker_model #(
    parameter int OPEN_CYCLES = 40
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // scenario control
    input wire logic faultOn,
    input wire logic stuck,
    // trip coil from the first power output
    input wire logic tripCoil,
    // fault seen by the protection
    output logic faultSeen
);
    int cnt;
    logic openReg;
    // a healthy breaker opens some time after its coil energises
    always_ff @(posedge sys_clk) begin
        if (!rstn || !faultOn) begin
            cnt <= 0;
            openReg <= 1'b0;
        end else if (tripCoil && !stuck && !openReg) begin
            cnt <= cnt + 1;
            if (cnt == OPEN_CYCLES - 1) begin
                openReg <= 1'b1;
            end
        end
    end
    // a stuck breaker never clears the fault
    assign faultSeen = faultOn && !openReg;
endmodule

// ===== testbench/relay_output_config_switchgroup_bench.sv
`timescale 1ns/1ps
`include "roc_defs.svh"
module relay_output_config_switchgroup_bench;
    import roc_pkg::*;
    localparam int TK = 4;
    logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic lockoutIn, tcsWarnIn, lightWarnIn, unlatchPanelIn, unlatchDinIn;
    logic ce, faultOn, stuck, faultSeen, configErr, irq;
    logic [1:0] tripHi;
    logic [2:0] powerOut;
    logic [4:0] sigIn, signalOut;
    logic [7:0] outs;
    int num_errors = 0;
    int total_checks = 0;
    assign outs = {signalOut, powerOut};
    roc_relay_top #(.TICK_CYCLES(TK)) uut (.sys_clk(sys_clk), .rstn(rstn),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tripIn({tripHi, faultSeen}),
        .lockoutIn(lockoutIn), .sigIn(sigIn), .tcsWarnIn(tcsWarnIn),
        .lightWarnIn(lightWarnIn), .unlatchPanelIn(unlatchPanelIn),
        .unlatchDinIn(unlatchDinIn), .powerOut(powerOut),
        .signalOut(signalOut), .configErr(configErr), .irq(irq));
    roc_breaker_model brk (.sys_clk(sys_clk), .rstn(rstn),
        .faultOn(faultOn), .stuck(stuck), .tripCoil(powerOut[0]),
        .faultSeen(faultSeen));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check_val(input string w, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic check_span(input string w, input int lo, hi, g);
        total_checks++;
        if (g < lo || g > hi) begin
            num_errors++;
            $display("ERROR %s expected %0d..%0d seen %0d", w, lo, hi, g);
        end
    endtask
    // one full transfer; waits a fresh edge so signals never change twice
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd_chk(input string w, input logic [7:0] a,
        input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check_val(w, exp, q);
    endtask
    function automatic logic [7:0] csum(input logic [7:0] sw);
        csum = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (sw[i]) csum = csum + (8'h01 << i);
        end
    endfunction
    // verified setting, then forget the mismatch onset it caused
    task automatic cfg(input logic [7:0] sw);
        wr(`ROC_OFF_SWITCHES, {24'h0, sw});
        wr(`ROC_OFF_CHECKSUM, {24'h0, csum(sw)});
        wr(`ROC_OFF_IRQ_CLR, 32'h7);
    endtask
    task automatic wait_lvl(input int b, input logic v, input int lim,
        output int n);
        n = 0;
        while (outs[b] !== v && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
    endtask
    task automatic t_reset();
        logic [31:0] q;
        logic e;
        rd_chk("switches", `ROC_OFF_SWITCHES, 32'h0);
        rd_chk("delay", `ROC_OFF_BF_DELAY, 32'hA);
        rd_chk("irq enable", `ROC_OFF_IRQ_EN, 32'h0);
        apb(1'b0, 8'h40, 32'h0, q, e);
        check_val("unmapped err", 32'h1, {31'h0, e});
        check_val("unmapped data", 32'h0, q);
    endtask
    task automatic t_checksum();
        wr(`ROC_OFF_SWITCHES, 32'hA5);
        rd_chk("status", `ROC_OFF_STATUS, {23'h0, 1'b1, csum(8'hA5)});
        check_val("cfg error", 32'h1, {31'h0, configErr});
        rd_chk("irq status", `ROC_OFF_IRQ_STAT, 32'h1);
        wr(`ROC_OFF_IRQ_EN, 32'h1);
        @(posedge sys_clk);
        check_val("irq on", 32'h1, {31'h0, irq});
        wr(`ROC_OFF_IRQ_CLR, 32'h1);
        @(posedge sys_clk);
        check_val("irq off", 32'h0, {31'h0, irq});
        wr(`ROC_OFF_CHECKSUM, 32'hA5);
        repeat (2) @(posedge sys_clk);
        check_val("cfg match", 32'h0, {31'h0, configErr});
        cfg(8'h00);
        wr(`ROC_OFF_IRQ_EN, 32'h0);
    endtask
    task automatic t_latch();
        int n;
        cfg(8'h01);
        for (int s = 0; s < 3; s++) begin
            faultOn <= 1'b1;
            wait_lvl(0, 1'b1, 20, n);
            check_span("trip rise", 2, 5, n);
            repeat (400) @(posedge sys_clk);
            check_val("latched", 32'h1, {31'h0, powerOut[0]});
            faultOn <= 1'b0;
            if (s == 0) unlatchPanelIn <= 1'b1;
            if (s == 1) unlatchDinIn <= 1'b1;
            if (s == 2) wr(`ROC_OFF_CONTROL, 32'h1);
            repeat (4) @(posedge sys_clk);
            unlatchPanelIn <= 1'b0;
            unlatchDinIn <= 1'b0;
            wait_lvl(0, 1'b0, 10, n);
            check_span("unlatch", 0, 9, n);
        end
    endtask
    // short request; on-time counted from four cycles after the rise
    task automatic t_pulse(input int b, input logic [7:0] sw, input int ms);
        int n;
        cfg(sw);
        if (b == 0) faultOn <= 1'b1;
        else sigIn[b-3] <= 1'b1;
        wait_lvl(b, 1'b1, 20, n);
        repeat (4) @(posedge sys_clk);
        faultOn <= 1'b0;
        sigIn <= 5'h00;
        wait_lvl(b, 1'b0, 2000, n);
        check_span("pulse", ms * TK - 4, (ms + 4) * TK, n);
    endtask
    task automatic t_backup();
        int n;
        wr(`ROC_OFF_BF_DELAY, 32'h5);
        rd_chk("delay low", `ROC_OFF_BF_DELAY, 32'hA);
        wr(`ROC_OFF_BF_DELAY, 32'hC);
        rd_chk("delay", `ROC_OFF_BF_DELAY, 32'hC);
        wr(`ROC_OFF_IRQ_EN, 32'h2);
        for (int c = 0; c < 3; c++) begin
            cfg((c == 2) ? 8'h00 : 8'h20);
            stuck <= (c != 1);
            faultOn <= 1'b1;
            wait_lvl(0, 1'b1, 20, n);
            wait_lvl(1, 1'b1, 700, n);
            if (c == 0) begin
                check_span("backup delay", 120 * TK - 8, 120 * TK + 8, n);
                check_val("irq", 32'h1, {31'h0, irq});
                rd_chk("irq status", `ROC_OFF_IRQ_STAT, 32'h6);
                wr(`ROC_OFF_IRQ_CLR, 32'h2);
                @(posedge sys_clk);
                check_val("irq clr", 32'h0, {31'h0, irq});
            end else begin
                check_val("no backup", 32'h0, {31'h0, powerOut[1]});
            end
            faultOn <= 1'b0;
            repeat (500) @(posedge sys_clk);
        end
    endtask
    task automatic t_lockout();
        int n;
        cfg(8'h40);
        tripHi[1] <= 1'b1;
        repeat (10) @(posedge sys_clk);
        check_val("trip ignored", 32'h0, {31'h0, powerOut[2]});
        lockoutIn <= 1'b1;
        wait_lvl(2, 1'b1, 10, n);
        check_span("lockout", 2, 5, n);
        lockoutIn <= 1'b0;
        repeat (400) @(posedge sys_clk);
        cfg(8'h00);
        wait_lvl(2, 1'b1, 10, n);
        check_val("normal", 32'h1, {31'h0, powerOut[2]});
        tripHi <= 2'b00;
        repeat (400) @(posedge sys_clk);
    endtask
    task automatic t_warn();
        int n;
        wr(`ROC_OFF_SWITCHES, 32'h80);
        tcsWarnIn <= 1'b1;
        repeat (10) @(posedge sys_clk);
        check_val("unverified", 32'h0, {31'h0, signalOut[1]});
        tcsWarnIn <= 1'b0;
        wr(`ROC_OFF_CHECKSUM, 32'h80);
        for (int w = 0; w < 2; w++) begin
            tcsWarnIn <= (w == 0);
            lightWarnIn <= (w == 1);
            wait_lvl(4, 1'b1, 10, n);
            check_val("warn", 32'h1, {31'h0, signalOut[1]});
            tcsWarnIn <= 1'b0;
            lightWarnIn <= 1'b0;
            wait_lvl(4, 1'b0, 1000, n);
        end
    endtask
    // a frozen block keeps a running pulse alive; no bus traffic meanwhile
    task automatic t_freeze();
        int n;
        sigIn[2] <= 1'b1;
        wait_lvl(5, 1'b1, 20, n);
        sigIn <= 5'h00;
        ce <= 1'b0;
        repeat (600) @(posedge sys_clk);
        check_val("frozen", 32'h1, {31'h0, signalOut[2]});
        ce <= 1'b1;
        wait_lvl(5, 1'b0, 2000, n);
        check_span("thawed pulse", 80 * TK - 4, 84 * TK, n);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // the whole run needs about a quarter of this
    initial begin
        #300us;
        num_errors++;
        report_and_stop();
    end
    initial begin
        rstn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {lockoutIn, tcsWarnIn, lightWarnIn, unlatchPanelIn} = '0;
        {unlatchDinIn, faultOn, stuck, tripHi, sigIn} = '0;
        ce = 1'b1;
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset();
        t_checksum();
        t_latch();
        t_pulse(0, 8'h00, 80);
        t_pulse(0, 8'h10, 40);
        t_pulse(3, 8'h00, 80);
        t_pulse(7, 8'h08, 40);
        t_backup();
        t_lockout();
        t_warn();
        t_freeze();
        report_and_stop();
    end
endmodule
